// File: hw/cpu_bus_defs.svh
// Constants for the processor local bus interface
// Summary of operation
// - Shared lines carry address in the address state, data in later states.
// - Lowest address bit low in address state when the lower byte moves.
// - Shared lines active high, floated during interrupt acknowledge and bus hold.
// - Upper lines carry four top address bits for memory, low for I/O.
// - Upper lines carry status in second, third, wait and final states.
// - Interrupt-enable flag appears as status, refreshed every clock cycle.
// - Segment code on two status bits: 00 alt, 01 stack, 10 code, 11 data.
// - Upper address/status lines float while bus hold is acknowledged.
// - Upper-byte enable low in address state when the upper byte moves.
// - Upper-byte enable pin carries a status bit after the address state.
// - Upper-byte enable low in address state of first interrupt acknowledge.
// - Upper-byte enable active low, floated while the bus is held.
// - Read strobe low in second, third and wait states of reads.
// - Read strobe never low while the address is still driven.
// - Read strobe floats while bus hold is acknowledged.
// - Interrupt request sampled in the last cycle of each instruction.
// - Interrupt request synchronised and ignored when interrupts are disabled.
// - Wait instruction continues on poll input, else idles re-examining it.
// - Wait-poll input synchronised on every rising clock edge.
`ifndef CPU_BUS_DEFS_SVH
`define CPU_BUS_DEFS_SVH
`define FIFO_DEPTH 8
`define DATA_W 16
`define SEG_HI_BIT 1
`define SEG_LO_BIT 0
`define STAT_S6_BIT 3
`define STAT_IE_BIT 2
`define STAT_S7_VALUE 1'b0
`define STAT_S6_VALUE 1'b0
`define PIN_IDLE_ADDR 16'h0000
`define RD_STROBE_RESET 1'b1
`define UBE_RESET 1'b1
`define SYNC_STAGES 2
`endif

// File: hw/cpu_bus_pkg.sv
// Types shared by the local bus interface
package cpu_bus_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_SECOND = 3'h2,
        ST_THIRD = 3'h3,
        ST_WAIT = 3'h4,
        ST_FINAL = 3'h5
    } bus_state_e;
    typedef enum logic [2:0] {
        K_MEM_RD = 3'h0,
        K_MEM_WR = 3'h1,
        K_IO_RD = 3'h2,
        K_IO_WR = 3'h3,
        K_INTA = 3'h4
    } bus_kind_e;
    typedef enum logic [1:0] {
        W_WORD = 2'h0,
        W_UPPER = 2'h1,
        W_LOWER = 2'h2
    } width_e;
    typedef struct packed {
        bus_kind_e kind;
        width_e width;
        logic [1:0] seg;
        logic inta_first;
        logic [19:0] addr;
        logic [15:0] wdata;
    } bus_req_s;
    typedef struct packed {
        logic [15:0] ad;
        logic ad_oe;
        logic [3:0] addr_status;
        logic addr_status_oe;
        logic ube_status;
        logic ube_status_oe;
        logic rd_n;
        logic rd_n_oe;
    } bus_pins_s;
endpackage

// File: hw/data_fifo.sv
// Synchronous FIFO for read data returned from the local bus
`timescale 1ns/100ps
module data_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("data_fifo depth must be a power of two, at least 2");
        end
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            if (push && !pop) begin
                count_r <= count_r + (AW+1)'(1);
            end else if (pop && !push) begin
                count_r <= count_r - (AW+1)'(1);
            end
        end
    end
endmodule

// File: hw/cpu_local_bus_interface.sv
// Pin-level local bus sequencer with interrupt and wait-poll sampling
`timescale 1ns/100ps
`include "cpu_bus_defs.svh"
module cpu_local_bus_interface #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic req_valid,
    output logic req_ready,
    input wire cpu_bus_pkg::bus_req_s req,
    output logic rdata_valid,
    input wire logic rdata_ready,
    output logic [15:0] rdata,
    input wire logic [15:0] shared_addr_data_lines_in,
    output cpu_bus_pkg::bus_pins_s pins,
    input wire logic ready,
    input wire logic bus_hold_ack,
    input wire logic maskable_irq,
    input wire logic ie_flag,
    input wire logic instr_last_cycle,
    output logic irq_take,
    input wire logic wait_poll,
    input wire logic wait_exec,
    output logic wait_idle,
    output logic wait_done
);
    import cpu_bus_pkg::*;

    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("FIFO_DEPTH must be at least 2");
        end
    end

    bus_state_e state_r;
    bus_state_e state_nxt;
    bus_req_s cur_r;
    bus_pins_s pins_r;
    bus_pins_s pins_nxt;
    logic ie_r;
    logic [1:0] irq_sync_r;
    logic [1:0] poll_sync_r;
    logic irq_take_r;
    logic wait_idle_r;
    logic wait_done_r;
    logic req_ready_r;
    logic fifo_in_ready;
    logic capture;
    logic is_read;
    logic is_rd_nxt;
    logic start;

    // A read is only launched with FIFO room, so returned data never drops
    assign is_read = (req.kind == K_MEM_RD) || (req.kind == K_IO_RD) || (req.kind == K_INTA);
    assign start = (state_r == ST_IDLE) && req_valid && req_ready_r && !bus_hold_ack
        && (!is_read || fifo_in_ready);
    assign capture = ((state_r == ST_THIRD) || (state_r == ST_WAIT)) && ready
        && (cur_r.kind == K_MEM_RD || cur_r.kind == K_IO_RD || cur_r.kind == K_INTA);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_ADDR;
                end
            end
            ST_ADDR: state_nxt = ST_SECOND;
            ST_SECOND: state_nxt = ST_THIRD;
            ST_THIRD: state_nxt = ready ? ST_FINAL : ST_WAIT;
            ST_WAIT: state_nxt = ready ? ST_FINAL : ST_WAIT;
            ST_FINAL: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cur_r <= '0;
        end else if (start) begin
            cur_r <= req;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            req_ready_r <= 1'b0;
        end else begin
            req_ready_r <= (state_nxt == ST_IDLE) && !start;
        end
    end

    // Flag copy refreshed every cycle; the status line takes ie_flag itself, and a_ie_status compares it with this copy
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ie_r <= 1'b0;
        end else begin
            ie_r <= ie_flag;
        end
    end

    // Pin values worked out from the next state so every pin is a flop
    logic use_cur;
    bus_req_s r;
    assign use_cur = (state_r != ST_IDLE);
    assign is_rd_nxt = (r.kind == K_MEM_RD) || (r.kind == K_IO_RD);
    always_comb begin
        r = use_cur ? cur_r : req;
        pins_nxt.ad = `PIN_IDLE_ADDR;
        pins_nxt.ad_oe = 1'b0;
        pins_nxt.addr_status = 4'h0;
        pins_nxt.addr_status_oe = !bus_hold_ack;
        pins_nxt.ube_status = `UBE_RESET;
        pins_nxt.ube_status_oe = !bus_hold_ack;
        pins_nxt.rd_n = `RD_STROBE_RESET;
        pins_nxt.rd_n_oe = !bus_hold_ack;
        case (state_nxt)
            ST_ADDR: begin
                pins_nxt.ad_oe = (r.kind != K_INTA);
                pins_nxt.ad = r.addr[15:0];
                pins_nxt.ad[0] = (r.width == W_UPPER);
                if (r.kind == K_MEM_RD || r.kind == K_MEM_WR) begin
                    pins_nxt.addr_status = r.addr[19:16];
                end
                if (r.kind == K_INTA) begin
                    pins_nxt.ube_status = !r.inta_first && (r.width == W_LOWER);
                end else begin
                    pins_nxt.ube_status = (r.width == W_LOWER);
                end
            end
            ST_SECOND, ST_THIRD, ST_WAIT, ST_FINAL: begin
                pins_nxt.addr_status[`STAT_S6_BIT] = `STAT_S6_VALUE;
                pins_nxt.addr_status[`STAT_IE_BIT] = ie_flag;
                pins_nxt.addr_status[1:0] = r.seg;
                pins_nxt.ube_status = `STAT_S7_VALUE;
                pins_nxt.ad = r.wdata;
                pins_nxt.ad_oe = (r.kind == K_MEM_WR) || (r.kind == K_IO_WR);
                if (state_nxt != ST_FINAL) begin
                    // Strobe only while the address drive is already off
                    pins_nxt.rd_n = !is_rd_nxt;
                end
            end
            default: begin
                pins_nxt.ad_oe = 1'b0;
            end
        endcase
        if (bus_hold_ack) begin
            pins_nxt.ad_oe = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pins_r <= '{ad: `PIN_IDLE_ADDR, ad_oe: 1'b0, addr_status: 4'h0, addr_status_oe: 1'b0,
                ube_status: `UBE_RESET, ube_status_oe: 1'b0, rd_n: `RD_STROBE_RESET, rd_n_oe: 1'b0};
        end else begin
            pins_r <= pins_nxt;
        end
    end

    // Interrupt request passes two flops before it is looked at
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_sync_r <= 2'h0;
            irq_take_r <= 1'b0;
        end else begin
            irq_sync_r <= {irq_sync_r[0], maskable_irq};
            irq_take_r <= instr_last_cycle && ie_flag && irq_sync_r[1];
        end
    end

    // Wait-poll input synchronised on every rising edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            poll_sync_r <= 2'h0;
        end else begin
            poll_sync_r <= {poll_sync_r[0], wait_poll};
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wait_idle_r <= 1'b0;
            wait_done_r <= 1'b0;
        end else begin
            wait_done_r <= wait_exec && poll_sync_r[1] && !wait_done_r;
            wait_idle_r <= wait_exec && !poll_sync_r[1];
        end
    end

    logic [15:0] fifo_out;
    logic fifo_out_valid;
    logic rdata_valid_r;
    logic [15:0] rdata_r;
    data_fifo #(
        .WIDTH(`DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(capture),
        .in_ready(fifo_in_ready),
        .in_data(shared_addr_data_lines_in),
        .out_valid(fifo_out_valid),
        .out_ready(!rdata_valid_r || rdata_ready),
        .out_data(fifo_out)
    );

    // Output stage keeps rdata flop-driven while still draining at full rate
    // Pops only when it loads, so each word leaves once; adds one word of room
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_valid_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else if (!rdata_valid_r || rdata_ready) begin
            rdata_valid_r <= fifo_out_valid;
            if (fifo_out_valid) begin
                rdata_r <= fifo_out;
            end
        end
    end

    assign req_ready = req_ready_r;
    assign pins = pins_r;
    assign irq_take = irq_take_r;
    assign wait_idle = wait_idle_r;
    assign wait_done = wait_done_r;
    assign rdata_valid = rdata_valid_r;
    assign rdata = rdata_r;

    property p_addr_then_second;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == ST_ADDR |=> state_r == ST_SECOND ##1 state_r == ST_THIRD;
    endproperty
    a_addr_then_second: assert property (p_addr_then_second) else $error("bad state order");

    property p_wait_on_not_ready;
        @(posedge sys_clk) disable iff (!resetn)
        (state_r == ST_THIRD || state_r == ST_WAIT) && !ready |=> state_r == ST_WAIT;
    endproperty
    a_wait_on_not_ready: assert property (p_wait_on_not_ready) else $error("no wait state");

    property p_rd_not_with_addr;
        @(posedge sys_clk) disable iff (!resetn)
        !pins_r.rd_n && pins_r.rd_n_oe |-> !pins_r.ad_oe;
    endproperty
    a_rd_not_with_addr: assert property (p_rd_not_with_addr) else $error("strobe with address");

    property p_rd_strobe;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == ST_SECOND && (cur_r.kind == K_MEM_RD || cur_r.kind == K_IO_RD) && !bus_hold_ack
        |-> !pins_r.rd_n;
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe missing");

    property p_hold_float;
        @(posedge sys_clk) disable iff (!resetn)
        bus_hold_ack |=> !pins_r.ad_oe && !pins_r.addr_status_oe && !pins_r.ube_status_oe && !pins_r.rd_n_oe;
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("pins driven in hold");

    property p_inta_float;
        @(posedge sys_clk) disable iff (!resetn)
        state_r != ST_IDLE && cur_r.kind == K_INTA |-> !pins_r.ad_oe;
    endproperty
    a_inta_float: assert property (p_inta_float) else $error("lines driven in acknowledge");

    property p_io_upper_low;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == ST_ADDR && (cur_r.kind == K_IO_RD || cur_r.kind == K_IO_WR) |-> pins_r.addr_status == 4'h0;
    endproperty
    a_io_upper_low: assert property (p_io_upper_low) else $error("io upper lines not low");

    property p_ie_status;
        @(posedge sys_clk) disable iff (!resetn)
        state_r inside {ST_SECOND, ST_THIRD, ST_WAIT, ST_FINAL} |-> pins_r.addr_status[`STAT_IE_BIT] == ie_r;
    endproperty
    a_ie_status: assert property (p_ie_status) else $error("ie status wrong");

    property p_irq_masked;
        @(posedge sys_clk) disable iff (!resetn)
        !$past(ie_flag) |-> !irq_take_r;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt taken");

    property p_first_inta_ube;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == ST_ADDR && cur_r.kind == K_INTA && cur_r.inta_first && !bus_hold_ack |-> !pins_r.ube_status;
    endproperty
    a_first_inta_ube: assert property (p_first_inta_ube) else $error("ube high in first acknowledge");

    property p_lane_select;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == ST_ADDR && cur_r.kind != K_INTA
        |-> pins_r.ube_status == (cur_r.width == W_LOWER) && pins_r.ad[0] == (cur_r.width == W_UPPER);
    endproperty
    a_lane_select: assert property (p_lane_select) else $error("byte lane select wrong");

    property p_s7_status;
        @(posedge sys_clk) disable iff (!resetn)
        state_r inside {ST_SECOND, ST_THIRD, ST_WAIT, ST_FINAL} |-> pins_r.ube_status == `STAT_S7_VALUE;
    endproperty
    a_s7_status: assert property (p_s7_status) else $error("enable pin not showing status");

    c_read_with_wait: cover property (@(posedge sys_clk) disable iff (!resetn)
        state_r == ST_WAIT && cur_r.kind == K_MEM_RD ##1 state_r == ST_FINAL);
    c_write: cover property (@(posedge sys_clk) disable iff (!resetn)
        state_r == ST_FINAL && cur_r.kind == K_IO_WR);
    c_irq: cover property (@(posedge sys_clk) disable iff (!resetn) irq_take_r);
    c_fifo_full: cover property (@(posedge sys_clk) disable iff (!resetn) !fifo_in_ready);
endmodule

// File: bench/local_bus_memory_model.sv
// Memory and I/O device model on the far side of the multiplexed local bus
`timescale 1ns/100ps
module local_bus_memory_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire cpu_bus_pkg::bus_pins_s pins,
    input wire logic [3:0] wait_n,
    output logic ready,
    output logic [15:0] ad_drive,
    output logic [15:0] last_wr
);
    import cpu_bus_pkg::*;
    logic [15:0] addr_r;
    logic [4:0] cnt_r;
    logic ad_oe_d_r;
    // Cycle start seen as the shared lines turning on with the address
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 5'h1F;
            addr_r <= 16'h0000;
            ad_oe_d_r <= 1'b0;
            last_wr <= 16'h0000;
        end else begin
            ad_oe_d_r <= pins.ad_oe;
            if (pins.ad_oe && !ad_oe_d_r) begin
                addr_r <= pins.ad;
                cnt_r <= 5'h00;
            end else if (cnt_r != 5'h1F) begin
                cnt_r <= cnt_r + 5'h01;
            end
            if (cnt_r == 5'h00 && pins.ad_oe) begin
                last_wr <= pins.ad;
            end
        end
    end
    // Driven from a register, so already synchronous; holds the cycle for wait_n states
    assign ready = (cnt_r >= {1'b0, wait_n} + 5'h01);
    // Data only while the strobe gates it; otherwise it inverts every cycle, so the old word returns every other cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ad_drive <= 16'h0000;
        end else if (pins.rd_n_oe && !pins.rd_n) begin
            ad_drive <= addr_r ^ 16'h5A3C;
        end else begin
            ad_drive <= ~ad_drive;
        end
    end
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the local bus interface
`timescale 1ns/100ps
`include "cpu_bus_defs.svh"
module tb_top;
    import cpu_bus_pkg::*;
    logic sys_clk, resetn, req_valid, req_ready, rdata_valid, rdata_ready, ready, bus_hold_ack;
    logic maskable_irq, ie_flag, instr_last_cycle, irq_take, wait_poll, wait_exec, wait_idle, wait_done;
    logic [15:0] rdata, model_ad, bus_level, mem_last_wr;
    logic [3:0] wait_n;
    bus_req_s req;
    bus_pins_s pins;
    bus_pins_s tr [12];
    int tn, mismatches, comparisons;
    assign bus_level = pins.ad_oe ? pins.ad : model_ad;
    cpu_local_bus_interface #(.FIFO_DEPTH(8)) cpu_local_bus_interface_inst (
        .sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rdata_valid(rdata_valid), .rdata_ready(rdata_ready), .rdata(rdata),
        .shared_addr_data_lines_in(bus_level), .pins(pins), .ready(ready), .bus_hold_ack(bus_hold_ack),
        .maskable_irq(maskable_irq), .ie_flag(ie_flag), .instr_last_cycle(instr_last_cycle),
        .irq_take(irq_take), .wait_poll(wait_poll), .wait_exec(wait_exec), .wait_idle(wait_idle),
        .wait_done(wait_done));
    local_bus_memory_model local_bus_memory_model_inst (
        .sys_clk(sys_clk), .resetn(resetn), .pins(pins), .wait_n(wait_n), .ready(ready),
        .ad_drive(model_ad), .last_wr(mem_last_wr));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (!ok) begin
            mismatches++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic bus_req_s mk(bus_kind_e k, width_e w, logic [1:0] s, logic [19:0] a, logic [15:0] d);
        return '{kind: k, width: w, seg: s, inta_first: k == K_INTA, addr: a, wdata: d};
    endfunction
    // Holds the request until req_ready drops, then records the pins once per cycle
    task automatic bus_cycle(input bus_req_s r, input int limit, output logic taken);
        int i;
        taken = 1'b0;
        for (i = 0; i < limit && req_ready !== 1'b1; i++) @(negedge sys_clk);
        req = r;
        req_valid = 1'b1;
        for (i = 0; i < limit && !taken; i++) begin
            @(negedge sys_clk);
            taken = (req_ready === 1'b0);
        end
        req_valid = 1'b0;
        for (tn = 0; taken && tn < 12 && req_ready !== 1'b1; tn++) begin
            tr[tn] = pins;
            @(negedge sys_clk);
        end
    endtask
    task automatic drain(input logic [15:0] exp, input logic cmp);
        int i;
        for (i = 0; i < 20 && rdata_valid !== 1'b1; i++) @(negedge sys_clk);
        chk(rdata_valid === 1'b1, "no read data");
        if (cmp) chk(rdata === exp, "read data mismatch");
        rdata_ready = 1'b1;
        @(negedge sys_clk);
        rdata_ready = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic t_mem_write();
        bus_req_s r;
        logic taken;
        for (int s = 0; s < 4; s++) begin
            ie_flag = s[0];
            r = mk(K_MEM_WR, W_WORD, s[1:0], {4'hC - 4'(s), 12'h3A0, 4'(s * 2)}, 16'hBEE0 + 16'(s));
            bus_cycle(r, 20, taken);
            chk(taken && tr[0].ad === r.addr[15:0] && tr[0].ad_oe === 1'b1, "address phase");
            chk(tr[0].addr_status === r.addr[19:16] && tr[0].ube_status === 1'b0, "upper address");
            chk(tr[1].ad === r.wdata && tr[1].ube_status === `STAT_S7_VALUE, "data phase");
            chk(tr[1].addr_status === {`STAT_S6_VALUE, s[0], s[1:0]}, "status bits");
            chk(mem_last_wr === r.wdata, "write not seen");
        end
        $display("test mem_write done");
    endtask
    task automatic t_io_write();
        bus_req_s r;
        logic taken;
        for (int w = 0; w < 3; w++) begin
            r = mk(K_IO_WR, width_e'(w), 2'h0, 20'hF0345, 16'h00C0 + 16'(w));
            bus_cycle(r, 20, taken);
            chk(taken && tr[0].ad === {r.addr[15:1], w == 1} && tr[0].ube_status === (w == 2), "lane");
            chk(tr[0].addr_status === 4'h0, "io upper lines not low");
        end
        $display("test io_write done");
    endtask
    task automatic t_read(input bus_kind_e k, input logic [3:0] waits, input logic [19:0] a);
        logic taken;
        int n;
        wait_n = waits;
        bus_cycle(mk(k, W_WORD, 2'h3, a, 16'h0000), 40, taken);
        chk(taken && tr[0].rd_n === 1'b1 && tr[0].ad_oe === 1'b1, "strobe in address state");
        chk(tr[1].ad_oe === 1'b0 && tr[1].rd_n === 1'b0, "strobe after release");
        n = 0;
        for (int i = 0; i < tn; i++) if (tr[i].rd_n === 1'b0) n++;
        chk(n == 2 + waits, "strobe length");
        drain(a[15:0] ^ 16'h5A3C, 1'b1);
        $display("test read done");
    endtask
    task automatic t_inta();
        logic taken;
        bus_cycle(mk(K_INTA, W_WORD, 2'h2, 20'h00000, 16'h0000), 20, taken);
        chk(taken && tr[0].ube_status === 1'b0 && tr[0].ube_status_oe === 1'b1, "first ack enable");
        chk(tr[0].ad_oe === 1'b0 && tr[1].ad_oe === 1'b0 && tr[2].ad_oe === 1'b0, "ack lines driven");
        drain(16'h0000, 1'b0);
        $display("test inta done");
    endtask
    task automatic t_hold();
        logic taken;
        bus_hold_ack = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(pins.ad_oe === 1'b0 && pins.addr_status_oe === 1'b0, "lines driven in hold");
        chk(pins.ube_status_oe === 1'b0 && pins.rd_n_oe === 1'b0, "enable or strobe driven");
        bus_cycle(mk(K_MEM_WR, W_WORD, 2'h1, 20'h40010, 16'h7E57), 8, taken);
        chk(taken === 1'b0, "cycle started in hold");
        @(negedge sys_clk);
        bus_hold_ack = 1'b0;
        bus_cycle(mk(K_MEM_WR, W_WORD, 2'h1, 20'h40010, 16'h7E57), 20, taken);
        chk(taken && mem_last_wr === 16'h7E57, "cycle after hold");
        $display("test hold done");
    endtask
    task automatic t_fifo();
        logic taken;
        // Eight buffered words plus the one held in the output stage
        for (int i = 0; i < 9; i++) begin
            bus_cycle(mk(K_MEM_RD, W_WORD, 2'h0, 20'h02000 + 20'(i * 2), 16'h0000), 20, taken);
            chk(taken, "read not taken");
        end
        bus_cycle(mk(K_MEM_RD, W_WORD, 2'h0, 20'h02012, 16'h0000), 10, taken);
        chk(taken === 1'b0, "read taken with buffer full");
        for (int i = 0; i < 9; i++) drain((16'h2000 + 16'(i * 2)) ^ 16'h5A3C, 1'b1);
        bus_cycle(mk(K_MEM_RD, W_WORD, 2'h0, 20'h02012, 16'h0000), 20, taken);
        drain(16'h2012 ^ 16'h5A3C, 1'b1);
        $display("test fifo done");
    endtask
    task automatic t_irq();
        int n;
        maskable_irq = 1'b1;
        for (int e = 1; e >= 0; e--) begin
            ie_flag = e[0];
            repeat (3) @(negedge sys_clk);
            instr_last_cycle = 1'b1;
            @(negedge sys_clk);
            instr_last_cycle = 1'b0;
            n = 0;
            repeat (4) begin
                if (irq_take === 1'b1) n++;
                @(negedge sys_clk);
            end
            chk(n == e, "interrupt take count");
        end
        maskable_irq = 1'b0;
        $display("test irq done");
    endtask
    task automatic t_wait();
        int n;
        wait_exec = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(wait_idle === 1'b1 && wait_done === 1'b0, "not idling while poll low");
        wait_poll = 1'b1;
        n = 0;
        repeat (6) begin
            @(negedge sys_clk);
            if (wait_done === 1'b1) begin
                n++;
                wait_exec = 1'b0;
            end
        end
        chk(n == 1, "no continue on poll");
        wait_poll = 1'b0;
        $display("test wait done");
    endtask
    initial begin
        #(40 * 5000);
        mismatches++;
        $display("BAD %0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        {resetn, req_valid, rdata_ready, bus_hold_ack, maskable_irq, ie_flag} = 6'h00;
        {instr_last_cycle, wait_poll, wait_exec} = 3'h0;
        wait_n = 4'h0;
        req = '0;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(pins.ad_oe === 1'b0 && pins.rd_n === `RD_STROBE_RESET && pins.ube_status === `UBE_RESET,
            "reset pins");
        resetn = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_mem_write();
        t_io_write();
        t_read(K_MEM_RD, 4'h0, 20'h1ABC4);
        t_read(K_IO_RD, 4'h2, 20'h00310);
        t_inta();
        t_hold();
        t_fifo();
        t_irq();
        t_wait();
        tally_and_finish();
    end
endmodule
